// ==== verilog/dcf_params.svh ====
// constants for the deep buffer: widths, depth, offset field layout, reset values
// assumes inclusion by bare name from each design file that needs them
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

`define DCF_WIDTH      18             // data word width
`define DCF_DEPTH      32             // words held by the buffer
`define DCF_AW         5              // pointer width
`define DCF_HALF_CNT   6'h10          // half full threshold (occupancy above it)
`define DCF_FULL_CNT   6'h20          // occupancy when full
`define DCF_LAST_CNT   6'h1F          // occupancy one below full
`define DCF_ONE_CNT    6'h01          // occupancy of a single word
`define DCF_AE_LSB     0              // almost-empty offset field, low bit
`define DCF_AE_MSB     8              // almost-empty offset field, high bit
`define DCF_AF_LSB     9              // almost-full offset field, low bit
`define DCF_AF_MSB     17             // almost-full offset field, high bit
`define DCF_OFS_RST    18'h01008      // offset register reset value
`define DCF_SYNC_W     28             // width of the synchronised pin bundle
`define DCF_SYNC_RST   28'h00003C1    // idle levels of the pin bundle

`endif

// ==== verilog/dcf_pkg.sv ====
// types shared by the deep buffer design
// assumes nothing of its surroundings
package dcf_pkg;

   // depth cascade token ownership
   typedef enum logic {
      DCF_TOK_IDLE,
      DCF_TOK_HELD
   } dcf_tok_t;

endpackage

// ==== verilog/dcf_sync.sv ====
// two flip-flop synchroniser for a bundle of pin inputs
// assumes clk_i is the only clock and resetn_i is synchronous, active low
`timescale 1ns/100ps
module dcf_sync #(
   parameter int               W       = 1,
   parameter logic [W-1:0]     RST_VAL = '0
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   // pins in, synchronised out
   input  wire logic [W-1:0] pins_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta;   // first stage, read only by the second

   // both stages load the idle levels under reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         meta   <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta   <= pins_i;
         sync_o <= meta;
      end
   end

endmodule // dcf_sync

// ==== verilog/dcf_fifo_store.sv ====
// flip-flop word store with pointers, occupancy count and replay
// assumes one clock; depth is a power of two equal to 2**AW
`timescale 1ns/100ps
module dcf_fifo_store #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   // control
   input  wire logic             clear_i,
   input  wire logic             replay_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o,
   // occupancy
   output logic      [AW:0]      count_o
);

   logic [WIDTH-1:0] mem [DEPTH];   // word storage
   logic [AW-1:0]    wr_ptr;        // next slot to fill
   logic [AW-1:0]    rd_ptr;        // oldest word
   logic             push;          // word accepted
   logic             pop;           // word taken
   logic [AW:0]      written;       // words stored since the clear, held at DEPTH
   logic [AW:0]      next_written;  // written after this cycle

   // refuse fills when full, drains when empty
   assign in_ready_o  = (count_o != (AW+1)'(DEPTH));
   assign out_valid_o = (count_o != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_i_ok();
   assign out_data_o  = mem[rd_ptr];
   assign next_written = written + (AW+1)'(push && (written != (AW+1)'(DEPTH)));

   function automatic logic out_valid_i_ok();
      return out_valid_o & out_ready_i & ~replay_i;
   endfunction

   // storage, written only on an accepted fill
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers; replay rewinds the read side to the first word written
   always_ff @(posedge clk_i) begin
      if (!resetn_i || clear_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(push);
         if (replay_i) begin
            rd_ptr <= '0;
         end else begin
            rd_ptr <= rd_ptr + AW'(pop);
         end
      end
   end

   // words stored since the clear; a full store wraps the write pointer to zero,
   // so the pointer alone cannot tell replay how many words there are
   always_ff @(posedge clk_i) begin
      if (!resetn_i || clear_i) begin
         written <= '0;
      end else begin
         written <= next_written;
      end
   end

   // occupancy; after replay every word since the clear is readable again
   always_ff @(posedge clk_i) begin
      if (!resetn_i || clear_i) begin
         count_o <= '0;
      end else if (replay_i) begin
         count_o <= next_written;
      end else begin
         count_o <= count_o + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule // dcf_fifo_store

// ==== verilog/dcf_top.sv ====
// deep buffer core: word path, offset register, status flags, cascade tokens
// assumes every pin input is asynchronous to clk_i and is synchronised here
//
// Functional notes
// - data in and data out are 18 bits
// - enabled write stores word unless full
// - enabled read presents next word unless empty
// - load with write fills offset register
// - load with read returns offset register
// - empty flag low when no words stored
// - full flag low when at capacity
// - almost-empty flag, registered or direct
// - almost-full flag, registered or direct
// - half-full pin doubles as write token
// - standalone replay strobe rewinds read side
// - read token passed to next device
// - buffer reset empties store and pointers
// - data driven only while enable low
// - empty transitions come from clk_i edges
// - six decodable occupancy states exposed
`timescale 1ns/100ps
`include "dcf_params.svh"
module dcf_top (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   input  wire logic                   buffer_reset_n_i,
   // write port
   input  wire logic [`DCF_WIDTH-1:0]  wr_data_i,
   input  wire logic                   write_enable_n_i,
   // read port
   input  wire logic                   read_enable_n_i,
   input  wire logic                   output_drive_enable_n_i,
   output logic      [`DCF_WIDTH-1:0]  rd_data_o,
   output logic                        rd_data_oe_o,
   // configuration
   input  wire logic                   offset_load_n_i,
   input  wire logic                   flag_sync_select_i,
   input  wire logic                   cascade_mode_i,
   input  wire logic                   first_device_or_replay_i,
   // cascade tokens
   input  wire logic                   write_cascade_in_i,
   input  wire logic                   read_cascade_in_i,
   output logic                        read_cascade_out_o,
   output logic                        write_cascade_out_or_half_full_o,
   // status flags
   output logic                        empty_flag_n_o,
   output logic                        full_flag_n_o,
   output logic                        almost_empty_flag_n_o,
   output logic                        almost_full_flag_n_o
);
   import dcf_pkg::*;

   // synchronised pins
   logic [`DCF_SYNC_W-1:0] sync_bus;     // bundle after two stages
   logic [`DCF_WIDTH-1:0]  s_wdata;      // write data
   logic                   s_wen_n;      // write enable
   logic                   s_ren_n;      // read enable
   logic                   s_ld_n;       // offset load
   logic                   s_oe_n;       // output drive enable
   logic                   s_sel;        // direct almost flags when high
   logic                   s_flrt;       // first device / replay strobe
   logic                   s_wxi;        // write token in
   logic                   s_rxi;        // read token in
   logic                   s_casc;       // depth cascade in use
   logic                   s_rs_n;       // buffer reset

   // store interface
   logic                   fifo_in_valid;  // write offered to store
   logic                   fifo_in_ready;  // store has room
   logic                   fifo_out_valid; // store holds a word
   logic                   fifo_out_ready; // read offered to store
   logic [`DCF_WIDTH-1:0]  fifo_out_data;  // oldest word
   logic [`DCF_AW:0]       fifo_count;     // occupancy

   // internal state
   logic [`DCF_WIDTH-1:0]  offset_reg;   // packed flag offsets
   dcf_tok_t               wtok;         // write token state
   dcf_tok_t               rtok;         // read token state
   logic                   wxi_prev;     // previous write token level
   logic                   rxi_prev;     // previous read token level
   logic                   flrt_prev;    // previous replay level
   logic                   ae_stage;     // registered almost-empty term
   logic                   af_stage;     // registered almost-full term
   logic                   wtok_pass;    // write token leaving this cycle
   logic                   rtok_pass;    // read token leaving this cycle

   // decoded terms
   logic                   clear;        // empty the store
   logic                   replay;       // rewind read side
   logic                   wr_ok;        // this device may write
   logic                   rd_ok;        // this device may read
   logic                   wr_fire;      // word stored this cycle
   logic                   rd_fire;      // word taken this cycle
   logic                   ld_write;     // offset register loaded
   logic                   ld_read;      // offset register read
   logic                   ae_now;       // occupancy at or below offset
   logic                   af_now;       // free space at or below offset
   logic                   hf_now;       // more than half full
   logic [8:0]             occ_w;        // occupancy widened to offset width
   logic [8:0]             free_w;       // free space widened to offset width

   // every pin input passes two flip-flops before use
   dcf_sync #(
      .W       (`DCF_SYNC_W),
      .RST_VAL (`DCF_SYNC_RST)
   ) u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .pins_i   ({wr_data_i, write_enable_n_i, read_enable_n_i, offset_load_n_i,
                  output_drive_enable_n_i, flag_sync_select_i,
                  first_device_or_replay_i, write_cascade_in_i, read_cascade_in_i,
                  cascade_mode_i, buffer_reset_n_i}),
      .sync_o   (sync_bus)
   );

   assign {s_wdata, s_wen_n, s_ren_n, s_ld_n, s_oe_n, s_sel,
           s_flrt, s_wxi, s_rxi, s_casc, s_rs_n} = sync_bus;

   // access decode; cascaded devices write and read the store only while holding the token, offset loads and reads need none
   assign clear    = ~s_rs_n;
   assign replay   = ~s_casc & flrt_prev & ~s_flrt;
   assign wr_ok    = ~s_casc | (wtok == DCF_TOK_HELD);
   assign rd_ok    = ~s_casc | (rtok == DCF_TOK_HELD);
   assign ld_write = ~s_ld_n & ~s_wen_n;
   assign ld_read  = ~s_ld_n & ~s_ren_n;
   assign fifo_in_valid  = ~s_wen_n & s_ld_n & wr_ok & ~clear;
   assign fifo_out_ready = ~s_ren_n & s_ld_n & rd_ok & ~clear;
   assign wr_fire  = fifo_in_valid & fifo_in_ready;
   assign rd_fire  = fifo_out_ready & fifo_out_valid & ~replay;

   // token leaves when this device fills up or drains out
   assign wtok_pass = s_casc & wr_fire & (fifo_count == `DCF_LAST_CNT);
   assign rtok_pass = s_casc & rd_fire & (fifo_count == `DCF_ONE_CNT);

   // flag thresholds against the programmed offsets
   assign occ_w  = {3'h0, fifo_count};
   assign free_w = {3'h0, `DCF_FULL_CNT - fifo_count};
   assign ae_now = occ_w  <= offset_reg[`DCF_AE_MSB:`DCF_AE_LSB];
   assign af_now = free_w <= offset_reg[`DCF_AF_MSB:`DCF_AF_LSB];
   assign hf_now = fifo_count > `DCF_HALF_CNT;

   // word store; depth is a parameter, one clock so pointers need no crossing
   dcf_fifo_store #(
      .WIDTH (`DCF_WIDTH),
      .DEPTH (`DCF_DEPTH),
      .AW    (`DCF_AW)
   ) u_store (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .clear_i     (clear),
      .replay_i    (replay),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (s_wdata),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data),
      .count_o     (fifo_count)
   );

   // programmable offset register
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         offset_reg <= `DCF_OFS_RST;
      end else if (ld_write) begin
         offset_reg <= s_wdata;
      end
   end

   // output word: offset on a load read, next word on a read, else held
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rd_data_o <= '0;
      end else if (ld_read) begin
         rd_data_o <= offset_reg;
      end else if (rd_fire) begin
         rd_data_o <= fifo_out_data;
      end
   end

   // drive enable for the data pins
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rd_data_oe_o <= 1'b0;
      end else begin
         rd_data_oe_o <= ~s_oe_n;
      end
   end

   // previous levels for edge detection
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wxi_prev  <= 1'b0;
         rxi_prev  <= 1'b0;
         flrt_prev <= 1'b0;   // idle pin level, so no false replay after reset
      end else begin
         wxi_prev  <= s_wxi;
         rxi_prev  <= s_rxi;
         flrt_prev <= s_flrt;
      end
   end

   // write token: first device starts with it, a rising pulse brings it back
   always_ff @(posedge clk_i) begin
      if (!resetn_i || clear) begin
         wtok <= s_flrt ? DCF_TOK_IDLE : DCF_TOK_HELD;
      end else begin
         unique case (wtok)
            DCF_TOK_IDLE: begin
               if (s_wxi && !wxi_prev) begin
                  wtok <= DCF_TOK_HELD;
               end
            end
            DCF_TOK_HELD: begin
               if (wtok_pass) begin
                  wtok <= DCF_TOK_IDLE;
               end
            end
         endcase
      end
   end

   // read token: same scheme on the read side
   always_ff @(posedge clk_i) begin
      if (!resetn_i || clear) begin
         rtok <= s_flrt ? DCF_TOK_IDLE : DCF_TOK_HELD;
      end else begin
         unique case (rtok)
            DCF_TOK_IDLE: begin
               if (s_rxi && !rxi_prev) begin
                  rtok <= DCF_TOK_HELD;
               end
            end
            DCF_TOK_HELD: begin
               if (rtok_pass) begin
                  rtok <= DCF_TOK_IDLE;
               end
            end
         endcase
      end
   end

   // shared half-full / write token pin and read token pin
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         write_cascade_out_or_half_full_o <= 1'b1;
         read_cascade_out_o               <= 1'b0;
      end else begin
         if (s_casc) begin
            write_cascade_out_or_half_full_o <= wtok_pass;
         end else begin
            write_cascade_out_or_half_full_o <= ~hf_now;
         end
         read_cascade_out_o <= rtok_pass;
      end
   end

   // empty and full flags follow the registered occupancy
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         empty_flag_n_o <= 1'b0;
         full_flag_n_o  <= 1'b1;
      end else begin
         empty_flag_n_o <= (fifo_count != '0);
         full_flag_n_o  <= (fifo_count != `DCF_FULL_CNT);
      end
   end

   // almost flags: extra stage when registered, direct term otherwise
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ae_stage              <= 1'b0;
         af_stage              <= 1'b1;
         almost_empty_flag_n_o <= 1'b0;
         almost_full_flag_n_o  <= 1'b1;
      end else begin
         ae_stage <= ~ae_now;
         af_stage <= ~af_now;
         if (s_sel) begin
            almost_empty_flag_n_o <= ~ae_now;
            almost_full_flag_n_o  <= ~af_now;
         end else begin
            almost_empty_flag_n_o <= ae_stage;
            almost_full_flag_n_o  <= af_stage;
         end
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence seq_cleared;
      (fifo_count == '0) ##1 !empty_flag_n_o;
   endsequence

   a_clear_empties:   assert property (clear |=> seq_cleared)
      else $error("buffer reset did not empty the store");
   a_empty_flag:      assert property ((fifo_count == '0) |=> !empty_flag_n_o)
      else $error("empty flag not low with no words");
   a_full_flag:       assert property ((fifo_count == `DCF_FULL_CNT) |=> !full_flag_n_o)
      else $error("full flag not low at capacity");
   a_full_refuse:     assert property ((fifo_count == `DCF_FULL_CNT) && !rd_fire && !clear
                                       && !replay |=> fifo_count == `DCF_FULL_CNT)
      else $error("occupancy moved while full with no read");
   a_write_counts:    assert property (wr_fire && !rd_fire && !clear && !replay
                                       |=> fifo_count == $past(fifo_count) + 6'h01)
      else $error("accepted write did not raise occupancy");
   a_read_word:       assert property (rd_fire && !ld_read
                                       |=> rd_data_o == $past(fifo_out_data))
      else $error("read did not present the oldest word");
   a_empty_hold:      assert property ((fifo_count == '0) && s_ld_n
                                       |=> $stable(rd_data_o))
      else $error("output word changed on a read while empty");
   a_offset_load:     assert property (ld_write |=> offset_reg == $past(s_wdata))
      else $error("offset register not loaded");
   a_offset_read:     assert property (ld_read |=> rd_data_o == $past(offset_reg))
      else $error("offset register not returned on read");
   a_drive_enable:    assert property (!s_oe_n ##1 !s_oe_n |-> rd_data_oe_o)
      else $error("data pins not driven while enable low");
   a_ae_direct:       assert property (s_sel && ae_now |=> !almost_empty_flag_n_o)
      else $error("direct almost-empty flag late");
   a_af_direct:       assert property (s_sel && af_now |=> !almost_full_flag_n_o)
      else $error("direct almost-full flag late");

   // half-full pin, cascade tokens, replay and full release
   a_half_full:       assert property (!s_casc && hf_now
                                       |=> !write_cascade_out_or_half_full_o)
      else $error("half-full pin not low above half");
   a_write_token:     assert property (wtok_pass |=> write_cascade_out_or_half_full_o)
      else $error("write token pulse missing");
   a_read_token:      assert property (rtok_pass |=> read_cascade_out_o)
      else $error("read token pulse missing");
   a_token_gate:      assert property (s_casc && (wtok == DCF_TOK_IDLE) && !rd_fire
                                       && !clear |=> $stable(fifo_count))
      else $error("write taken without the write token");
   a_token_load:      assert property (clear && !s_flrt
                                       |=> (wtok == DCF_TOK_HELD) && (rtok == DCF_TOK_HELD))
      else $error("first device did not take both tokens");
   a_replay_count:    assert property (replay && !clear
                                       |=> fifo_count >= $past(fifo_count))
      else $error("replay lost readable words");
   a_full_release:    assert property ((fifo_count != `DCF_FULL_CNT) |=> full_flag_n_o)
      else $error("full flag low below capacity");

endmodule // dcf_top

// ==== dv/dcf_bus_model.sv ====
// reader-side model: resolves the three-state data wire that the reader sees
// assumes the buffer's data output and its drive enable are registered on clk_i
`timescale 1ns/100ps
module dcf_bus_model #(
   parameter int W = 18              // data word width
) (
   // clock
   input  wire logic         clk_i,
   // buffer side
   input  wire logic [W-1:0] data_i,
   input  wire logic         oe_i,
   // reader side
   output logic      [W-1:0] bus_o
);
   logic [W-1:0] last;               // last value driven onto the wire

   // remember the driven value so a released wire can differ from it
   always_ff @(posedge clk_i) begin
      if (oe_i) begin
         last <= data_i;
      end
   end

   // no keeper on the wire: a released bus shows the inverse, never a stale copy
   assign bus_o = oe_i ? data_i : ~last;
endmodule // dcf_bus_model

// ==== dv/dcf_top_test.sv ====
// self-checking bench for the deep buffer core
// assumes one clock for both sides and pins synchronised two edges inside the core
`timescale 1ns/100ps
`include "dcf_params.svh"
module dcf_top_test;
   // flag vector order: empty, full, almost empty, almost full, half full
   typedef struct {int occ; logic [4:0] fl;} dcf_row_t;

   logic                  clk_i = 1'b0;          // 100 ns clock
   logic                  resetn_i = 1'b0;       // core reset, active low
   logic                  buffer_reset_n_i = 1'b1;
   logic [`DCF_WIDTH-1:0] wr_data_i = '0;
   logic                  write_enable_n_i = 1'b1;
   logic                  read_enable_n_i = 1'b1;
   logic                  output_drive_enable_n_i = 1'b0;
   logic                  offset_load_n_i = 1'b1;
   logic                  flag_sync_select_i = 1'b0;
   logic                  cascade_mode_i = 1'b0;
   logic                  first_device_or_replay_i = 1'b0; // standalone: low
   logic                  write_cascade_in_i = 1'b0;       // not cascaded: low
   logic                  read_cascade_in_i = 1'b0;        // not cascaded: low
   logic [`DCF_WIDTH-1:0] rd_data_o;
   logic                  rd_data_oe_o;
   logic                  read_cascade_out_o;
   logic                  write_cascade_out_or_half_full_o;
   logic                  empty_flag_n_o;
   logic                  full_flag_n_o;
   logic                  almost_empty_flag_n_o;
   logic                  almost_full_flag_n_o;
   logic [`DCF_WIDTH-1:0] bus;                   // resolved data wire
   logic [4:0]            flags;                 // status pins as one vector
   int                    fails = 0;             // mismatches
   int                    checks_done = 0;       // comparisons made
   int                    done = 0;              // words written since clear
   int                    wxo_pulses = 0;        // write token pulses seen
   int                    rxo_pulses = 0;        // read token pulses seen
   int                    base_w = 0;            // write pulses before a scenario
   int                    base_r = 0;            // read pulses before a scenario
   // ordinary cases: fill level reached and the flags it must give
   dcf_row_t rows [8] = '{'{1, 5'h1B}, '{8, 5'h1B}, '{9, 5'h1F}, '{16, 5'h1F},
                          '{17, 5'h1E}, '{24, 5'h1C}, '{31, 5'h1C}, '{32, 5'h14}};

   assign flags = {empty_flag_n_o, full_flag_n_o, almost_empty_flag_n_o,
                   almost_full_flag_n_o, write_cascade_out_or_half_full_o};

   dcf_top u_dcf_top (.clk_i(clk_i), .resetn_i(resetn_i), .buffer_reset_n_i(buffer_reset_n_i),
      .wr_data_i(wr_data_i), .write_enable_n_i(write_enable_n_i),
      .read_enable_n_i(read_enable_n_i), .output_drive_enable_n_i(output_drive_enable_n_i),
      .rd_data_o(rd_data_o), .rd_data_oe_o(rd_data_oe_o), .offset_load_n_i(offset_load_n_i),
      .flag_sync_select_i(flag_sync_select_i), .cascade_mode_i(cascade_mode_i),
      .first_device_or_replay_i(first_device_or_replay_i),
      .write_cascade_in_i(write_cascade_in_i), .read_cascade_in_i(read_cascade_in_i),
      .read_cascade_out_o(read_cascade_out_o),
      .write_cascade_out_or_half_full_o(write_cascade_out_or_half_full_o),
      .empty_flag_n_o(empty_flag_n_o), .full_flag_n_o(full_flag_n_o),
      .almost_empty_flag_n_o(almost_empty_flag_n_o),
      .almost_full_flag_n_o(almost_full_flag_n_o));

   dcf_bus_model u_dcf_bus_model (.clk_i(clk_i), .data_i(rd_data_o), .oe_i(rd_data_oe_o),
      .bus_o(bus));

   // free-running clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // count token pulses on the cascade outputs, sampled mid-cycle
   always @(negedge clk_i) begin
      wxo_pulses += int'(write_cascade_out_or_half_full_o);
      rxo_pulses += int'(read_cascade_out_o);
   end

   // compare one value and count it
   task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // write n back-to-back words starting at base, then let flags settle
   task automatic wr(input int n, input logic [17:0] base);
      for (int k = 0; k < n; k++) begin
         @(negedge clk_i);
         write_enable_n_i = 1'b0;
         wr_data_i = base + 18'(k);
      end
      @(negedge clk_i);
      write_enable_n_i = 1'b1;
      repeat (6) @(negedge clk_i);
   endtask

   // one read strobe, then wait past the synchroniser and output register
   task automatic rd();
      @(negedge clk_i);
      read_enable_n_i = 1'b0;
      @(negedge clk_i);
      read_enable_n_i = 1'b1;
      repeat (5) @(negedge clk_i);
   endtask

   // report counts and the verdict, then stop
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // cut a hang short
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      give_verdict();
   end

   // main sequence
   initial begin
      repeat (16) @(negedge clk_i);
      resetn_i = 1'b1;                                    // reset before any access
      repeat (4) @(negedge clk_i);
      chk("reset flags", 18'(flags), 18'h0000B);
      chk("reset data", rd_data_o, 18'h00000);
      // fill level table: flags at each threshold boundary
      foreach (rows[i]) begin
         wr(rows[i].occ - done, 18'h15000 + 18'(done));
         done = rows[i].occ;
         chk("fill flags", 18'(flags), 18'(rows[i].fl));
      end
      // write while full is refused
      wr(1, 18'h3FFFF);
      chk("full refuse", 18'(flags), 18'h00014);
      // drain in order, the refused word must not appear
      for (int i = 0; i < 32; i++) begin
         rd();
         chk("read word", bus, 18'h15000 + 18'(i));
      end
      chk("drained flags", 18'(flags), 18'h0000B);
      rd();
      chk("empty refuse", bus, 18'h1501F);
      // replay strobe rewinds the read side to the first word
      first_device_or_replay_i = 1'b1;
      repeat (4) @(negedge clk_i);
      first_device_or_replay_i = 1'b0;
      repeat (6) @(negedge clk_i);
      rd();
      chk("replay word", bus, 18'h15000);
      chk("replay flags", 18'(flags), 18'h0001C);
      // buffer reset pin empties the store
      buffer_reset_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      buffer_reset_n_i = 1'b1;
      repeat (6) @(negedge clk_i);
      chk("clear flags", 18'(flags), 18'h0000B);
      // offset register load and read back, direct flag mode
      flag_sync_select_i = 1'b1;
      offset_load_n_i = 1'b0;
      wr(1, 18'h00404);
      rd();
      offset_load_n_i = 1'b1;
      chk("offset read", bus, 18'h00404);
      wr(4, 18'h00100);
      chk("ae at offset", 18'(flags), 18'h0001B);
      wr(1, 18'h00104);
      chk("ae above", 18'(flags), 18'h0001F);
      // depth cascade as first device: both tokens start here and leave when used
      cascade_mode_i = 1'b1;
      buffer_reset_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      buffer_reset_n_i = 1'b1;
      repeat (6) @(negedge clk_i);
      base_w = wxo_pulses;
      base_r = rxo_pulses;
      wr(32, 18'h2A000);
      chk("write token out", 18'(wxo_pulses - base_w), 18'h00001);
      repeat (32) rd();
      chk("cascade last word", rd_data_o, 18'h2A01F);
      chk("read token out", 18'(rxo_pulses - base_r), 18'h00001);
      wr(1, 18'h2B000);
      chk("no token refuse", 18'(empty_flag_n_o), 18'h00000);
      write_cascade_in_i = 1'b1;
      @(negedge clk_i);
      write_cascade_in_i = 1'b0;
      wr(1, 18'h2B000);
      chk("token back write", 18'(empty_flag_n_o), 18'h00001);
      // release the data pins
      output_drive_enable_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk("drive off", 18'(rd_data_oe_o), 18'h00000);
      give_verdict();
   end
endmodule // dcf_top_test
